/* File: verilog/adcc_pkg.sv */
// Purpose: Shared constants for the converter control block
// Assumes: 250 MHz system clock
// Notes:   Mode register bit positions and timing counts
package adcc_pkg;
	localparam int          CLK_MHZ        = 250;
	localparam int          MODE_START_POS = 7;
	localparam int          MODE_ENABLE_POS = 0;
	localparam logic [7:0]  MODE_RESET     = 8'h00;
	localparam logic [1:0]  CHAN_RESET     = 2'h0;
	localparam logic [9:0]  RESULT_RESET   = 10'h000;
	localparam int          SETTLE_US      = 1;
	localparam int          SETTLE_CYCLES  = SETTLE_US * CLK_MHZ;
	localparam int          SAMPLE_CYCLES  = 8;
	localparam int          RES_BITS       = 10;
	localparam int          CNT_W          = 9;
	typedef enum logic [1:0] {ADCC_OFF, ADCC_WAIT, ADCC_SAMPLE, ADCC_CONVERT} adcc_state_t;
endpackage

/* File: verilog/adcc_sar.sv */
// Purpose: Successive-approximation step engine for one conversion
// Assumes: Comparator input already synchronised by the caller
// Notes:   Ten steps, MSB first; restart reloads it with only the MSB set
`timescale 1ns/1ps
module adcc_sar (
	input  wire logic                           clock,
	input  wire logic                           rst_n,
	input  wire logic                           go,
	input  wire logic                           abort,
	input  wire logic                           cmp_high,
	output logic [adcc_pkg::RES_BITS-1:0]       sar,
	output logic                                done
);
	import adcc_pkg::*;
	logic [3:0] bit_idx;
	logic       busy;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sar <= RESULT_RESET;
			bit_idx <= 4'h0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				busy <= 1'b0;
			end else if (go) begin
				busy <= 1'b1;
				bit_idx <= 4'(RES_BITS - 1);
				sar <= 10'h200;
			end else if (busy) begin
				if (!cmp_high)
					sar[bit_idx] <= 1'b0;
				if (bit_idx == 4'h0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					sar[bit_idx - 4'h1] <= 1'b1;
					bit_idx <= bit_idx - 4'h1;
				end
			end
		end
	end
endmodule

/* File: verilog/adcc_ctrl.sv */
// Purpose: Converter control: registers, conflicts, flag, power state
// Assumes: CPU strobes are on the same clock; comparator is a pin input
// Notes:   Mode and channel registers written through plain strobes
//
// Notes on behaviour
// - Result read coinciding with store returns old value, store lands after.
// - Mode or channel write at store time wins; store and interrupt dropped.
// - Channel rewrite never clears the conversion-end flag.
// - First result after early start is suspect; software discards it.
// - Software reads result before writing mode or channel.
// - Start 0 with enable 1 holds a waiting state, comparator only powered.
// - Conversion period spans sampling through result, sampling included.
// - Full result holds ten bits in sixteen; high result holds top eight.
// - Mode or channel write during conversion aborts and restarts if started.
// - Each completion without a coinciding mode or channel write stores result, raises request, and starts again.
`timescale 1ns/1ps
module adcc_ctrl (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        mode_we,
	input  wire logic [7:0]  mode_wdata,
	input  wire logic        chan_we,
	input  wire logic [1:0]  chan_wdata,
	input  wire logic        result_re,
	input  wire logic        flag_clear,
	input  wire logic        comparator_in,
	output logic [7:0]       converter_mode_register,
	output logic [1:0]       channel_select_register,
	output logic [15:0]      result_register_full,
	output logic [7:0]       result_register_high,
	output logic             conversion_end_request_flag,
	output logic             conversion_end_interrupt,
	output logic             comparator_power,
	output logic             sample_switch,
	output logic             converting,
	output logic             first_result_suspect
);
	import adcc_pkg::*;

	// ----------------------------------------
	// Input synchroniser and state
	// ----------------------------------------
	logic                  cmp_meta;
	logic                  cmp_sync;
	adcc_state_t           state;
	logic [CNT_W-1:0]      count;
	logic                  sar_go;
	logic                  sar_done;
	logic [RES_BITS-1:0]   sar_value;
	logic                  pending;
	logic [RES_BITS-1:0]   pending_value;
	logic                  cfg_write;
	logic                  start_bit;
	logic                  enable_bit;
	logic [CNT_W-1:0]      settle_cnt;
	logic                  store_now;

	assign cfg_write  = mode_we | chan_we;
	assign start_bit  = converter_mode_register[MODE_START_POS];
	assign enable_bit = converter_mode_register[MODE_ENABLE_POS];
	assign store_now  = sar_done & ~cfg_write;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
		end else begin
			cmp_meta <= comparator_in;
			cmp_sync <= cmp_meta;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			converter_mode_register <= MODE_RESET;
			channel_select_register <= CHAN_RESET;
		end else begin
			if (mode_we)
				converter_mode_register <= mode_wdata;
			if (chan_we)
				channel_select_register <= chan_wdata;
		end
	end

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= ADCC_OFF;
			count <= '0;
			sar_go <= 1'b0;
		end else begin
			sar_go <= 1'b0;
			if (!enable_bit && !start_bit) begin
				state <= ADCC_OFF;
			end else if (cfg_write || !start_bit) begin
				state <= ADCC_WAIT;
			end else begin
				case (state)
					ADCC_OFF, ADCC_WAIT: begin
						state <= ADCC_SAMPLE;
						count <= '0;
					end
					ADCC_SAMPLE: begin
						if (count == CNT_W'(SAMPLE_CYCLES - 1)) begin
							state <= ADCC_CONVERT;
							sar_go <= 1'b1;
						end else begin
							count <= count + 1'b1;
						end
					end
					ADCC_CONVERT: begin
						if (sar_done) begin
							state <= ADCC_SAMPLE;
							count <= '0;
						end
					end
					default: state <= ADCC_OFF;
				endcase
			end
		end
	end

	adcc_sar u_sar (
		.clock    (clock),
		.rst_n    (rst_n),
		.go       (sar_go),
		.abort    (cfg_write | ~start_bit),
		.cmp_high (cmp_sync),
		.sar      (sar_value),
		.done     (sar_done)
	);

	// ----------------------------------------
	// Result store with read priority
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			result_register_full <= 16'h0000;
			result_register_high <= 8'h00;
			pending <= 1'b0;
			pending_value <= RESULT_RESET;
		end else if (store_now && result_re) begin
			pending <= 1'b1;
			pending_value <= sar_value;
		// Register writes leave the results as they were
		end else if (store_now || (pending && !result_re)) begin
			pending <= 1'b0;
			result_register_full <= {6'h00, store_now ? sar_value : pending_value};
			result_register_high <= store_now ? sar_value[9:2] : pending_value[9:2];
		end
	end

	// ----------------------------------------
	// Request flag and interrupt pulse
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			conversion_end_request_flag <= 1'b0;
			conversion_end_interrupt <= 1'b0;
		end else begin
			conversion_end_interrupt <= store_now;
			// Channel writes leave the flag alone; set beats clear
			if (store_now)
				conversion_end_request_flag <= 1'b1;
			else if (flag_clear)
				conversion_end_request_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// Power and status outputs
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			comparator_power <= 1'b0;
			sample_switch <= 1'b0;
			converting <= 1'b0;
			settle_cnt <= '0;
			first_result_suspect <= 1'b0;
		end else begin
			comparator_power <= enable_bit | start_bit;
			sample_switch <= (state == ADCC_SAMPLE) && start_bit && !cfg_write;
			converting <= (state == ADCC_SAMPLE) || (state == ADCC_CONVERT);
			if (!enable_bit)
				settle_cnt <= '0;
			else if (settle_cnt != CNT_W'(SETTLE_CYCLES))
				settle_cnt <= settle_cnt + 1'b1;
			if (state == ADCC_WAIT || state == ADCC_OFF)
				first_result_suspect <= start_bit && settle_cnt != CNT_W'(SETTLE_CYCLES);
			else if (store_now)
				first_result_suspect <= 1'b0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	read_first_a: assert property (@(posedge clock) disable iff (!rst_n)
		store_now && result_re |=> $stable(result_register_full) ##1 result_register_full[9:0] == $past(sar_value, 2))
		else $error("result store did not follow the read");
	write_wins_a: assert property (@(posedge clock) disable iff (!rst_n)
		sar_done && cfg_write |=> !conversion_end_interrupt && $stable(result_register_full))
		else $error("store performed despite register write");
	flag_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
		chan_we && !flag_clear && conversion_end_request_flag |=> conversion_end_request_flag)
		else $error("flag cleared by channel write");
	wait_power_a: assert property (@(posedge clock) disable iff (!rst_n)
		!start_bit && enable_bit ##1 !start_bit |-> comparator_power && !sample_switch && !converting)
		else $error("waiting state not held");
	high_copy_a: assert property (@(posedge clock) disable iff (!rst_n)
		result_register_high == result_register_full[9:2] || $past(pending))
		else $error("high result mismatch");
	sequence cfg_then_start_s;
		cfg_write ##1 (start_bit && !cfg_write);
	endsequence
	sequence idle_then_sample_s;
		(state == ADCC_OFF || state == ADCC_WAIT) ##1 (state == ADCC_SAMPLE && !converting);
	endsequence
	abort_a: assert property (@(posedge clock) disable iff (!rst_n)
		cfg_then_start_s |-> idle_then_sample_s)
		else $error("write did not restart conversion");
	restart_a: assert property (@(posedge clock) disable iff (!rst_n)
		store_now && start_bit && !mode_we |=> conversion_end_interrupt && state == ADCC_SAMPLE)
		else $error("next conversion not started");
	sample_len_a: assert property (@(posedge clock) disable iff (!rst_n)
		sar_go |-> $past(state, 8) == ADCC_SAMPLE || $past(cfg_write, 8))
		else $error("sampling not inside conversion");
endmodule

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the converter control block
// Assumes: Comparator level held steady within one conversion
// Notes:   Store edge is found from the measured conversion period
`timescale 1ns/1ps
module testbench;
	import adcc_pkg::*;
	logic        clock = 0, rst_n = 0, mode_we = 0, chan_we = 0, result_re = 0;
	logic        flag_clear = 0, comparator_in = 0, lvl, mon_on = 1;
	logic [7:0]  mode_wdata = 8'h00, mode_q, high_q;
	logic [1:0]  chan_wdata = 2'h0, chan_q;
	logic [15:0] full_q, m_v;
	logic        flag_q, int_q, pwr_q, samp_q, conv_q, susp_q;
	logic [15:0] exp_q[$];
	int          mismatches = 0, samples_checked = 0, per, n;

	adcc_ctrl dut (.clock(clock), .rst_n(rst_n), .mode_we(mode_we), .mode_wdata(mode_wdata),
		.chan_we(chan_we), .chan_wdata(chan_wdata), .result_re(result_re),
		.flag_clear(flag_clear), .comparator_in(comparator_in),
		.converter_mode_register(mode_q), .channel_select_register(chan_q),
		.result_register_full(full_q), .result_register_high(high_q),
		.conversion_end_request_flag(flag_q), .conversion_end_interrupt(int_q),
		.comparator_power(pwr_q), .sample_switch(samp_q), .converting(conv_q),
		.first_result_suspect(susp_q));

	always #2 clock = ~clock;

	//------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------
	task check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	function automatic logic [15:0] val(input logic l);
		return l ? 16'h03FF : 16'h0000;
	endfunction

	task results;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task tick(input int k);
		repeat (k) @(negedge clock);
	endtask

	task wr_mode(input logic [7:0] d);
		mode_we = 1;
		mode_wdata = d;
		tick(1);
		mode_we = 0;
	endtask

	task wait_int(output int c);
		c = 0;
		do begin
			tick(1);
			c++;
		end while (int_q !== 1'b1 && c < 400);
		if (c >= 400)
			check(16'h0000, 16'h0001);
	endtask

	// Result monitor takes the oldest note on each interrupt
	always @(negedge clock) begin
		if (mon_on && int_q === 1'b1 && exp_q.size() > 0) begin
			m_v = exp_q.pop_front();
			check(full_q, m_v);
			check({8'h00, high_q}, {8'h00, m_v[9:2]});
		end
	end

	initial begin
		repeat (3000) @(posedge clock);
		mismatches++;
		results;
	end

	//------------------------------------------------------------
	// Tests
	//------------------------------------------------------------
	initial begin
		void'($urandom(59));
		lvl = 1'($urandom % 2);
		tick(10);
		rst_n = 1;
		tick(1);
		check({6'h00, conv_q, flag_q, mode_q}, 16'h0000);
		wr_mode(8'h80);
		tick(3);
		check({14'h0, susp_q, conv_q}, 16'h0003);
		wr_mode(8'h00);
		tick(1);
		wr_mode(8'h01);
		tick(SETTLE_CYCLES + 10);
		check({13'h0, pwr_q, samp_q, conv_q}, 16'h0004);
		$display("test wait state done");
		check({15'h0, conv_q}, 16'h0000);
		comparator_in = lvl;
		wr_mode(8'h81);
		tick(3);
		check({13'h0, susp_q, samp_q, conv_q}, 16'h0003);
		exp_q.push_back(val(lvl));
		exp_q.push_back(val(lvl));
		wait_int(n);
		wait_int(per);
		tick(1);
		check({15'h0, flag_q}, 16'h0001);
		check(16'(exp_q.size()), 16'h0000);
		chan_we = 1;
		chan_wdata = 2'h2;
		tick(1);
		chan_we = 0;
		tick(1);
		check({13'h0, flag_q, chan_q}, 16'h0006);
		check(full_q, val(lvl));
		flag_clear = 1;
		tick(1);
		flag_clear = 0;
		tick(1);
		check({15'h0, flag_q}, 16'h0000);
		$display("test conversion done");
		mon_on = 0;
		wait_int(n);
		lvl = ~lvl;
		comparator_in = lvl;
		tick(per - 1);
		result_re = 1;
		tick(1);
		result_re = 0;
		check(full_q, val(~lvl));
		tick(1);
		check(full_q, val(lvl));
		wait_int(n);
		lvl = ~lvl;
		comparator_in = lvl;
		tick(per - 1);
		chan_we = 1;
		tick(1);
		chan_we = 0;
		repeat (3) begin
			check({15'h0, int_q}, 16'h0000);
			tick(1);
		end
		check(full_q, val(~lvl));
		$display("test conflicts done");
		wait_int(n);
		tick(per / 2);
		wr_mode(8'h81);
		wait_int(n);
		check({15'h0, n >= per}, 16'h0001);
		wr_mode(8'h00);
		tick(2);
		check({13'h0, pwr_q, conv_q, samp_q}, 16'h0000);
		$display("test restart and stop done");
		results;
	end
endmodule
